/* File: shared/ccc_pkg.sv */
// Constants, types and opcode timing for the flag and operand execution block.
// Assumes one core clock; all counts are in core clock cycles.
`default_nettype none

package ccc_pkg;

   // Register map
   localparam logic [7:0] CCC_FLAGS_ADDR = 8'hD5;
   localparam logic [7:0] CCC_FLAGS_RST = 8'h00;

   // Flag bit positions inside condition_flags
   localparam int CCC_FLAG_C = 7;
   localparam int CCC_FLAG_Z = 6;
   localparam int CCC_FLAG_S = 5;
   localparam int CCC_FLAG_V = 4;
   localparam int CCC_FLAG_D = 3;
   localparam int CCC_FLAG_H = 2;

   // Opcodes
   localparam logic [7:0] CCC_OP_INV_CARRY = 8'hEF;
   localparam logic [7:0] CCC_OP_ZERO_R = 8'hB0;
   localparam logic [7:0] CCC_OP_ZERO_IR = 8'hB1;
   localparam logic [7:0] CCC_OP_COM_R = 8'h60;
   localparam logic [7:0] CCC_OP_COM_IR = 8'h61;
   localparam logic [7:0] CCC_OP_CMP_RR = 8'hA2;
   localparam logic [7:0] CCC_OP_CMP_RIR = 8'hA3;
   localparam logic [7:0] CCC_OP_CMP_DD = 8'hA4;
   localparam logic [7:0] CCC_OP_CMP_DIR = 8'hA5;
   localparam logic [7:0] CCC_OP_CMP_IMM = 8'hA6;

   // Execution times in core cycles
   localparam logic [3:0] CCC_CYC_SHORT = 4'h4;
   localparam logic [3:0] CCC_CYC_LONG = 4'h6;
   localparam logic [3:0] CCC_CYC_NONE = 4'h0;

   typedef enum logic [1:0] {
      CCC_ST_IDLE,
      CCC_ST_EXEC
   } ccc_state_e;

   // Cycles taken by an opcode; zero marks an opcode this block does not run
   function automatic logic [3:0] ccc_op_cycles(input logic [7:0] op);
      logic [3:0] cyc;
      cyc = CCC_CYC_NONE;
      case (op)
         CCC_OP_INV_CARRY, CCC_OP_ZERO_R, CCC_OP_ZERO_IR,
         CCC_OP_COM_R, CCC_OP_COM_IR, CCC_OP_CMP_RR: cyc = CCC_CYC_SHORT;
         CCC_OP_CMP_RIR, CCC_OP_CMP_DD, CCC_OP_CMP_DIR,
         CCC_OP_CMP_IMM: cyc = CCC_CYC_LONG;
         default: cyc = CCC_CYC_NONE;
      endcase
      return cyc;
   endfunction : ccc_op_cycles

   function automatic logic ccc_is_cmp(input logic [7:0] op);
      return (op >= CCC_OP_CMP_RR) && (op <= CCC_OP_CMP_IMM);
   endfunction : ccc_is_cmp

endpackage : ccc_pkg

`default_nettype wire

/* File: shared/ccc_op_if.sv */
// Operand and flag bundle between the sequencer and the flag calculator.
// Assumes the sequencer holds the operands stable while an operation runs.
`default_nettype none

interface ccc_op_if;
   logic [7:0] opcode;
   logic [7:0] dst;
   logic [7:0] src;
   logic [7:0] flags_in;
   logic [7:0] result;
   logic [7:0] flags_out;
   logic writes_dst;

   modport core (output opcode, output dst, output src, output flags_in,
                 input result, input flags_out, input writes_dst);
   modport calc (input opcode, input dst, input src, input flags_in,
                 output result, output flags_out, output writes_dst);
endinterface : ccc_op_if

`default_nettype wire

/* File: hdl/ccc_flag_calc.sv */
// Combinational result and flag calculation for the four operations.
// Assumes opcode and operands are held by the caller; no state inside.
`default_nettype none

module ccc_flag_calc
   import ccc_pkg::*;
(
   ccc_op_if.calc bus
);

   logic [8:0] diff9;
   logic [7:0] com_val;
   logic cmp_ovf;

   assign diff9 = {1'b0, bus.dst} - {1'b0, bus.src};
   assign com_val = ~bus.dst;
   // Signed overflow: operand signs differ and result sign leaves dst
   assign cmp_ovf = (bus.dst[7] ^ bus.src[7]) & (bus.dst[7] ^ diff9[7]);

   always_comb begin
      bus.result = bus.dst;
      bus.flags_out = bus.flags_in;
      bus.writes_dst = 1'b0;
      case (bus.opcode)
         CCC_OP_INV_CARRY: begin
            bus.flags_out[CCC_FLAG_C] = ~bus.flags_in[CCC_FLAG_C];
         end
         CCC_OP_ZERO_R, CCC_OP_ZERO_IR: begin
            bus.result = 8'h00;
            bus.writes_dst = 1'b1;
         end
         CCC_OP_COM_R, CCC_OP_COM_IR: begin
            bus.result = com_val;
            bus.writes_dst = 1'b1;
            bus.flags_out[CCC_FLAG_Z] = (com_val == 8'h00);
            bus.flags_out[CCC_FLAG_S] = com_val[7];
            bus.flags_out[CCC_FLAG_V] = 1'b0;
         end
         CCC_OP_CMP_RR, CCC_OP_CMP_RIR, CCC_OP_CMP_DD, CCC_OP_CMP_DIR,
         CCC_OP_CMP_IMM: begin
            bus.result = diff9[7:0];
            bus.flags_out[CCC_FLAG_C] = diff9[8];
            bus.flags_out[CCC_FLAG_Z] = (diff9[7:0] == 8'h00);
            bus.flags_out[CCC_FLAG_S] = diff9[7];
            bus.flags_out[CCC_FLAG_V] = cmp_ovf;
         end
         default: begin
            bus.result = bus.dst;
         end
      endcase
   end

endmodule : ccc_flag_calc

`default_nettype wire

/* File: hdl/ccc_cycle_timer.sv */
// Down counter that marks the last cycle of an operation.
// Assumes load is only raised while the counter is idle.
`default_nettype none

module ccc_cycle_timer #(
   parameter int CNT_W = 4
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic load,
   input wire logic [CNT_W-1:0] load_value,
   output logic expire
);

   logic [CNT_W-1:0] cnt;

   generate
      if (CNT_W < 2) begin : g_bad_width
         $error("CNT_W too small for the expiry compare");
      end
   endgenerate

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cnt <= '0;
      end else if (load) begin
         cnt <= load_value;
      end else if (cnt != '0) begin
         cnt <= cnt - 1'b1;
      end
   end

   assign expire = (cnt == {{(CNT_W-1){1'b0}}, 1'b1});

endmodule : ccc_cycle_timer

`default_nettype wire

/* File: hdl/ccc_alu_core.sv */
// Execution unit for carry invert, clear, one's complement and compare.
// Assumes the decoder fetches both operands before raising op_valid and
// writes dst_result back itself when dst_we pulses.
//
// Local design decision: strobed register access.
`default_nettype none

// Behaviour
// - Carry invert flips carry, four cycles
// - Carry invert leaves other flags alone
// - Carry lives in flags register D5h
// - Complement inverts all destination bits
// - Complement: sign is bit 7; C,D,H kept
// - Complement always clears overflow
// - Complement and compare set zero flag
// - Compare carry means borrow occurred
// - Compare sign follows difference bit 7
// - Compare overflow is signed overflow; D,H kept
module ccc_alu_core
   import ccc_pkg::*;
#(
   parameter int CNT_W = 4
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic op_valid,
   input wire logic [7:0] opcode,
   input wire logic [7:0] dst_value,
   input wire logic [7:0] src_value,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic op_ready,
   output logic op_done,
   output logic dst_we,
   output logic [7:0] dst_result,
   output logic illegal_op,
   output logic [7:0] condition_flags_out,
   output logic [7:0] reg_rdata
);

   generate
      if (CNT_W < 3) begin : g_bad_width
         $error("CNT_W too small for the longest operation");
      end
   endgenerate

   ccc_state_e state;
   ccc_state_e next_state;
   logic [7:0] condition_flags;
   logic [7:0] q_opcode;
   logic [7:0] q_dst;
   logic [7:0] q_src;
   logic [7:0] next_flags;
   logic [7:0] next_rdata;

   wire [3:0] in_cycles = ccc_op_cycles(opcode);
   // Gated by op_ready so the edge that releases reset takes no request
   wire accept = op_ready && op_valid && (in_cycles != CCC_CYC_NONE);
   wire reject = op_ready && op_valid && (in_cycles == CCC_CYC_NONE);
   wire expire;
   wire commit = (state == CCC_ST_EXEC) && expire;
   wire flags_hit = (reg_addr == CCC_FLAGS_ADDR);
   wire sw_flags_wr = reg_wr && flags_hit;
   wire [CNT_W-1:0] timer_load = CNT_W'(in_cycles - 4'h1);

   ccc_op_if op_bus ();

   assign op_bus.opcode = q_opcode;
   assign op_bus.dst = q_dst;
   assign op_bus.src = q_src;
   assign op_bus.flags_in = condition_flags;

   ccc_flag_calc u_calc (
      .bus(op_bus)
   );

   ccc_cycle_timer #(
      .CNT_W(CNT_W)
   ) u_timer (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .load(accept),
      .load_value(timer_load),
      .expire(expire)
   );

   // Instruction update beats a software write in the same cycle
   assign next_flags = commit ? op_bus.flags_out : (sw_flags_wr ? reg_wdata : condition_flags);
   // Read data only in the cycle after the strobe, zero otherwise
   assign next_rdata = (reg_rd && flags_hit) ? condition_flags : 8'h00;

   always_comb begin
      next_state = state;
      case (state)
         CCC_ST_IDLE: begin
            if (accept) begin
               next_state = CCC_ST_EXEC;
            end
         end
         CCC_ST_EXEC: begin
            if (expire) begin
               next_state = CCC_ST_IDLE;
            end
         end
         default: begin
            next_state = CCC_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state <= CCC_ST_IDLE;
         op_ready <= 1'b0;
      end else begin
         state <= next_state;
         op_ready <= (next_state == CCC_ST_IDLE);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         q_opcode <= 8'h00;
         q_dst <= 8'h00;
         q_src <= 8'h00;
      end else if (accept) begin
         q_opcode <= opcode;
         q_dst <= dst_value;
         q_src <= src_value;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         condition_flags <= CCC_FLAGS_RST;
         condition_flags_out <= CCC_FLAGS_RST;
         reg_rdata <= 8'h00;
      end else begin
         condition_flags <= next_flags;
         condition_flags_out <= next_flags;
         reg_rdata <= next_rdata;
      end
   end

   // Operands are never written back by compare
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         op_done <= 1'b0;
         dst_we <= 1'b0;
         dst_result <= 8'h00;
         illegal_op <= 1'b0;
      end else begin
         op_done <= commit;
         dst_we <= commit && op_bus.writes_dst;
         if (commit) begin
            dst_result <= op_bus.result;
         end
         illegal_op <= reject;
      end
   end

   // Helpers read only by the checks below
   wire run_inv = commit && (q_opcode == CCC_OP_INV_CARRY);
   wire run_zero = commit && ((q_opcode == CCC_OP_ZERO_R) || (q_opcode == CCC_OP_ZERO_IR));
   wire run_com = commit && ((q_opcode == CCC_OP_COM_R) || (q_opcode == CCC_OP_COM_IR));
   wire run_cmp = commit && ccc_is_cmp(q_opcode);
   wire [7:0] c_mask = 8'h01 << CCC_FLAG_C;
   wire [7:0] cdh_mask = c_mask | (8'h01 << CCC_FLAG_D) | (8'h01 << CCC_FLAG_H);
   wire [7:0] dh_mask = (8'h01 << CCC_FLAG_D) | (8'h01 << CCC_FLAG_H);

   sequence s_accept_short;
      accept && (in_cycles == CCC_CYC_SHORT);
   endsequence

   sequence s_accept_long;
      accept && (in_cycles == CCC_CYC_LONG);
   endsequence

   sequence s_done_after_four;
      (!op_done)[*3] ##1 op_done;
   endsequence

   sequence s_done_after_six;
      (!op_done)[*5] ##1 op_done;
   endsequence

   a_short_op_timing: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      s_accept_short |-> ##1 s_done_after_four)
      else $error("four-cycle operation finished at the wrong cycle");

   a_long_op_timing: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      s_accept_long |-> ##1 s_done_after_six)
      else $error("six-cycle operation finished at the wrong cycle");

   a_carry_inverts: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      run_inv |=> (condition_flags[CCC_FLAG_C] != $past(condition_flags[CCC_FLAG_C])))
      else $error("carry was not inverted");

   a_carry_others_kept: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      run_inv |=> ((condition_flags & ~c_mask) == ($past(condition_flags) & ~c_mask)))
      else $error("carry invert disturbed another flag");

   a_flags_readback: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (reg_rd && (reg_addr == CCC_FLAGS_ADDR)) |=> (reg_rdata == $past(condition_flags)))
      else $error("flags register read returned wrong value");

   a_clear_zero: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      run_zero |=> (dst_we && (dst_result == 8'h00) && $stable(condition_flags)))
      else $error("clear did not write zero or changed flags");

   a_com_inverts: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      run_com |=> (dst_we && (dst_result == ~$past(q_dst))))
      else $error("complement result wrong");

   a_com_sign_kept: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      run_com |=> ((condition_flags[CCC_FLAG_S] == dst_result[7])
                   && ((condition_flags & cdh_mask) == ($past(condition_flags) & cdh_mask))))
      else $error("complement sign or kept flags wrong");

   a_com_ovf_clear: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      run_com |=> !condition_flags[CCC_FLAG_V])
      else $error("complement left overflow set");

   a_zero_flag: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (run_com || run_cmp) |=> (condition_flags[CCC_FLAG_Z] == ($past(op_bus.result) == 8'h00)))
      else $error("zero flag does not match result");

   a_cmp_no_write: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      run_cmp |=> !dst_we)
      else $error("compare wrote an operand");

   a_cmp_borrow: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      run_cmp |=> (condition_flags[CCC_FLAG_C] == ($past(q_src) > $past(q_dst))))
      else $error("compare carry does not show borrow");

   a_cmp_sign: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      run_cmp |=> (condition_flags[CCC_FLAG_S] == $past(op_bus.result[7])))
      else $error("compare sign wrong");

   a_cmp_overflow: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      run_cmp |=> ((condition_flags[CCC_FLAG_V] ==
                    (($past(q_dst[7]) ^ $past(q_src[7])) & ($past(q_dst[7]) ^ $past(op_bus.result[7]))))
                   && ((condition_flags & dh_mask) == ($past(condition_flags) & dh_mask))))
      else $error("compare overflow or kept flags wrong");

   a_busy_blocks_new: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (state == CCC_ST_EXEC) |-> !op_ready)
      else $error("ready shown while executing");

endmodule : ccc_alu_core

`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench for the carry invert, clear, complement and compare unit.
// Assumes the design asserts its own rules internally; the bench drives ports directly.
`default_nettype none

module tb_top;
   import ccc_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic op_valid = 1'b0;
   logic [7:0] opcode = 8'h00;
   logic [7:0] dst_value = 8'h00;
   logic [7:0] src_value = 8'h00;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic op_ready;
   logic op_done;
   logic dst_we;
   logic [7:0] dst_result;
   logic illegal_op;
   logic [7:0] condition_flags_out;
   logic [7:0] reg_rdata;
   int mismatches = 0;
   int num_checks = 0;
   int cycles = 0;
   logic [7:0] exp_f;

   ccc_alu_core ccc_alu_core_inst (
      .sys_clk(sys_clk), .rst_n(rst_n), .op_valid(op_valid), .opcode(opcode),
      .dst_value(dst_value), .src_value(src_value), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .op_ready(op_ready),
      .op_done(op_done), .dst_we(dst_we), .dst_result(dst_result),
      .illegal_op(illegal_op), .condition_flags_out(condition_flags_out),
      .reg_rdata(reg_rdata)
   );

   initial begin
      forever #4 sys_clk = ~sys_clk;
   end

   // Whole run needs well under a thousand cycles
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         summarize();
      end
   end

   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : summarize

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         $display("mismatch %s expected %h seen %h", name, exp, got);
         mismatches++;
      end
   endtask : chk

   function automatic logic [7:0] setf(input logic [7:0] f, input int pos, input logic b);
      logic [7:0] r;
      r = f;
      r[pos] = b;
      return r;
   endfunction : setf

   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk("reg_rdata", exp, reg_rdata);
      @(posedge sys_clk);
      #1;
      chk("reg_rdata after", 8'h00, reg_rdata);
   endtask : reg_read

   // Drives one operation, waits for retirement, judges timing, result and flags
   task automatic run_op(input logic [7:0] op, input logic [7:0] d, input logic [7:0] s,
                         input logic [7:0] res, input logic we);
      int n;
      logic [3:0] cyc;
      n = 0;
      cyc = (op inside {CCC_OP_CMP_RIR, CCC_OP_CMP_DD, CCC_OP_CMP_DIR, CCC_OP_CMP_IMM}) ?
            CCC_CYC_LONG : CCC_CYC_SHORT;
      @(posedge sys_clk);
      op_valid <= 1'b1;
      opcode <= op;
      dst_value <= d;
      src_value <= s;
      @(posedge sys_clk);
      op_valid <= 1'b0;
      do begin
         @(posedge sys_clk);
         #1;
         n++;
      end while (op_done !== 1'b1 && n < 20);
      chk("cycles", 8'(cyc - 4'h1), 8'(n));
      if (op != CCC_OP_INV_CARRY) begin
         chk("dst_result", res, dst_result);
      end
      chk("flags", exp_f, condition_flags_out);
      chk("dst_we", {7'h00, we}, {7'h00, dst_we});
      chk("op_ready", 8'h01, {7'h00, op_ready});
      @(posedge sys_clk);
      #1;
      chk("op_done pulse", 8'h00, {7'h00, op_done});
   endtask : run_op

   task automatic t_regs();
      reg_read(CCC_FLAGS_ADDR, 8'h00);
      reg_write(8'h12, 8'hFF);
      reg_read(8'h12, 8'h00);
      reg_write(CCC_FLAGS_ADDR, 8'h7C);
      reg_read(CCC_FLAGS_ADDR, 8'h7C);
      exp_f = 8'h7C;
   endtask : t_regs

   task automatic t_inv_carry();
      exp_f = setf(exp_f, CCC_FLAG_C, 1'b1);
      run_op(CCC_OP_INV_CARRY, 8'h00, 8'h00, 8'h00, 1'b0);
      exp_f = setf(exp_f, CCC_FLAG_C, 1'b0);
      run_op(CCC_OP_INV_CARRY, 8'h00, 8'h00, 8'h00, 1'b0);
      reg_read(CCC_FLAGS_ADDR, exp_f);
   endtask : t_inv_carry

   task automatic t_clear();
      reg_write(CCC_FLAGS_ADDR, 8'hAD);
      exp_f = 8'hAD;
      run_op(CCC_OP_ZERO_R, 8'h4F, 8'h11, 8'h00, 1'b1);
      run_op(CCC_OP_ZERO_IR, 8'h5E, 8'h22, 8'h00, 1'b1);
   endtask : t_clear

   task automatic t_complement();
      // Carry, decimal and half carry set beforehand so that keeping them shows
      reg_write(CCC_FLAGS_ADDR, 8'hDC);
      exp_f = 8'hAC;
      run_op(CCC_OP_COM_R, 8'h07, 8'h00, 8'hF8, 1'b1);
      exp_f = 8'hCC;
      run_op(CCC_OP_COM_IR, 8'hFF, 8'h00, 8'h00, 1'b1);
      exp_f = 8'h8C;
      run_op(CCC_OP_COM_IR, 8'hF1, 8'h00, 8'h0E, 1'b1);
   endtask : t_complement

   task automatic t_compare();
      logic [7:0] dd [4];
      logic [7:0] ss [4];
      logic [7:0] r;
      logic [7:0] op;
      dd = '{8'h02, 8'h05, 8'h80, 8'h7F};
      ss = '{8'h03, 8'h05, 8'h01, 8'hFF};
      reg_write(CCC_FLAGS_ADDR, 8'h0F);
      exp_f = 8'h0F;
      for (int k = 0; k < 5; k++) begin
         op = CCC_OP_CMP_RR + 8'(k);
         for (int i = 0; i < 4; i++) begin
            r = dd[i] - ss[i];
            exp_f = setf(exp_f, CCC_FLAG_C, ss[i] > dd[i]);
            exp_f = setf(exp_f, CCC_FLAG_Z, r == 8'h00);
            exp_f = setf(exp_f, CCC_FLAG_S, r[7]);
            exp_f = setf(exp_f, CCC_FLAG_V, (dd[i][7] ^ ss[i][7]) & (dd[i][7] ^ r[7]));
            run_op(op, dd[i], ss[i], r, 1'b0);
         end
      end
   endtask : t_compare

   // A request held high while busy must be dropped, not queued
   task automatic t_busy();
      reg_write(CCC_FLAGS_ADDR, 8'h00);
      exp_f = 8'h40;
      @(posedge sys_clk);
      op_valid <= 1'b1;
      opcode <= CCC_OP_CMP_IMM;
      dst_value <= 8'h33;
      src_value <= 8'h33;
      @(posedge sys_clk);
      opcode <= CCC_OP_INV_CARRY;
      repeat (4) @(posedge sys_clk);
      op_valid <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk("busy op_done", 8'h01, {7'h00, op_done});
      chk("busy flags", exp_f, condition_flags_out);
      repeat (6) @(posedge sys_clk);
      #1;
      chk("dropped op flags", exp_f, condition_flags_out);
      chk("dropped op ready", 8'h01, {7'h00, op_ready});
   endtask : t_busy

   task automatic t_illegal();
      @(posedge sys_clk);
      op_valid <= 1'b1;
      opcode <= 8'h00;
      @(posedge sys_clk);
      op_valid <= 1'b0;
      #1;
      chk("illegal_op", 8'h01, {7'h00, illegal_op});
      chk("op_ready", 8'h01, {7'h00, op_ready});
      chk("flags kept", exp_f, condition_flags_out);
      @(posedge sys_clk);
      #1;
      chk("illegal_op pulse", 8'h00, {7'h00, illegal_op});
   endtask : t_illegal

   initial begin
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      t_regs();
      t_inv_carry();
      t_clear();
      t_complement();
      t_compare();
      t_busy();
      t_illegal();
      repeat (4) @(posedge sys_clk);
      summarize();
   end

endmodule : tb_top

`default_nettype wire
